// ==== logic/cpsc_supply_ctrl.v ====
/*
  Charge pump supply controller: software-commanded sequencer that drives the
  transmitter's charge pump, supply switches and reservoir discharge through
  the device's serial register port, plus a transmit duty-cycle guard.
  Assumes the device implements transmitter_control_two and
  rf_trim_control_one as mapped in cpsc_regs.vh, and that software reaches
  this block by a one-cycle strobe port with read data one cycle later.
*/
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "cpsc_regs.vh"

// Behaviour
// - pump_run reads live charge state; controller polls it for completion
// - writing pump_run to zero ends the charge at once
// - both supply selects stay cleared during the whole charge
// - reservoir select is cleared before a new charge starts
// - charge: clear main, set run, wait clear, use reservoir, then back to main
// - discharge: select reservoir, set discharge bit, wait, reset transmitter
// - never both selects set; clear both before setting the other
// - charged capacitor is used by a transmission before main is reselected
// - with pump unused, reservoir select and discharge bit stay cleared; the code accepts reservoir-select and discharge commands with no charge
// - datagram under 1 s; silence at least 10 s or 30 times its length
module cpsc_supply_ctrl #(
  parameter MS_CYCLES = `CPSC_MS_NS / `CPSC_CLK_NS
) (
  // clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // software register port
  input  wire [3:0] sw_addr,
  input  wire [7:0] sw_wdata,
  input  wire       sw_wr,
  input  wire       sw_rd,
  output reg  [7:0] sw_rdata_r,
  output reg        irq_r,
  // device serial register port
  output wire       spi_sck,
  output wire       spi_mosi,
  output wire       spi_cs_n,
  input  wire       spi_miso,
  // device control pins
  output reg        xmt_reset_n_r,
  output reg        tx_enable_r
);

  localparam [3:0] S_IDLE      = 4'h0;
  localparam [3:0] S_XFER      = 4'h1;
  localparam [3:0] S_CHG_RUN   = 4'h2;
  localparam [3:0] S_POLL_WAIT = 4'h3;
  localparam [3:0] S_POLL_CHK  = 4'h4;
  localparam [3:0] S_SEL_SET   = 4'h5;
  localparam [3:0] S_DIS_BIT   = 4'h6;
  localparam [3:0] S_DIS_WAIT  = 4'h7;
  localparam [3:0] S_RESET     = 4'h8;

  reg  [3:0]  state_r;
  reg  [3:0]  ret_r;
  reg  [1:0]  pts_r;
  reg  [7:0]  dis_ms_r;
  reg  [7:0]  dis_cnt_r;
  reg  [5:0]  status_r;
  reg  [5:0]  mask_r;
  reg  [5:0]  ev_r;
  reg         run_r;
  reg         res_r;
  reg         main_r;
  reg         dis_r;
  reg         charged_r;
  reg         abort_pend_r;
  reg         want_res_r;
  reg         dis_op_r;
  reg         spi_start_r;
  reg         spi_rd_r;
  reg  [6:0]  spi_addr_r;
  reg  [7:0]  spi_wdata_r;
  reg  [15:0] tx_len_r;
  reg  [15:0] hold_r;
  reg         consumed_r;
  reg         hold_over_r;
  reg         tx_cut_r;
  wire        ms_tick;
  wire        spi_done;
  wire        spi_busy;
  wire [7:0]  spi_rdata;
  wire        cmd_wr = sw_wr && (sw_addr == `CPSC_A_CMD);
  wire        busy   = (state_r != S_IDLE);
  wire        tx_req = cmd_wr && sw_wdata[`CPSC_CMD_TX_START];
  wire        tx_end = cmd_wr && sw_wdata[`CPSC_CMD_TX_STOP];
  wire [15:0] hold_mul = tx_len_r * `CPSC_HOLD_MULT;
  wire        tx_ok  = !busy && !tx_enable_r && (hold_r == 16'h0000) && (res_r ^ main_r);

  // builds the transmitter_control_two byte from the shadow bits
  function [7:0] tcr2_byte;
    input       run;
    input [1:0] pts;
    input       res;
    input       main;
    begin
      tcr2_byte = `CPSC_BYTE_ZERO;
      tcr2_byte[`CPSC_TCR2_RUN]  = run;
      tcr2_byte[`CPSC_TCR2_PTS_HI:`CPSC_TCR2_PTS_LO] = pts;
      tcr2_byte[`CPSC_TCR2_RES]  = res;
      tcr2_byte[`CPSC_TCR2_MAIN] = main;
    end
  endfunction

  cpsc_ms_timer #(
    .MS_CYCLES (MS_CYCLES),
    .CNT_W     (16)
  ) u_ms (
    .clk     (clk),
    .reset_n (reset_n),
    .tick_r  (ms_tick)
  );

  cpsc_spi_master #(
    .HALF (`CPSC_SPI_HALF)
  ) u_spi (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (spi_start_r),
    .rd      (spi_rd_r),
    .addr    (spi_addr_r),
    .wdata   (spi_wdata_r),
    .busy_r  (spi_busy),
    .done_r  (spi_done),
    .rdata_r (spi_rdata),
    .sck_r   (spi_sck),
    .mosi_r  (spi_mosi),
    .cs_n_r  (spi_cs_n),
    .miso    (spi_miso)
  );

  // sequencer: every device access is one serial frame, then return to ret_r
  always @(posedge clk) begin
    if (!reset_n) begin
      state_r       <= S_IDLE;
      ret_r         <= S_IDLE;
      run_r         <= 1'b0;
      res_r         <= 1'b0;
      main_r        <= 1'b0;
      dis_r         <= 1'b0;
      charged_r     <= 1'b0;
      abort_pend_r  <= 1'b0;
      want_res_r    <= 1'b0;
      dis_op_r      <= 1'b0;
      dis_cnt_r     <= 8'h00;
      spi_start_r   <= 1'b0;
      spi_rd_r      <= 1'b0;
      spi_addr_r    <= 7'h00;
      spi_wdata_r   <= 8'h00;
      xmt_reset_n_r <= 1'b1;
      ev_r          <= 6'h00;
    end else begin
      spi_start_r <= 1'b0;
      ev_r        <= 6'h00;
      if (consumed_r && res_r)
        charged_r <= 1'b0;
      if (busy && cmd_wr && sw_wdata[`CPSC_CMD_ABORT] && run_r)
        abort_pend_r <= 1'b1;
      else if (busy && cmd_wr && (sw_wdata[`CPSC_CMD_CHARGE] || sw_wdata[`CPSC_CMD_SEL_RES] ||
                                  sw_wdata[`CPSC_CMD_SEL_MAIN] || sw_wdata[`CPSC_CMD_DISCHARGE]))
        ev_r[`CPSC_EV_REFUSED] <= 1'b1;
      case (state_r)
        S_IDLE: begin
          if (cmd_wr && sw_wdata[`CPSC_CMD_CHARGE]) begin
            if (tx_enable_r) begin
              ev_r[`CPSC_EV_REFUSED] <= 1'b1;
            end else begin
              // both selects dropped before the pump starts
              res_r       <= 1'b0;
              main_r      <= 1'b0;
              spi_start_r <= 1'b1;
              spi_rd_r    <= `CPSC_FRAME_WRITE;
              spi_addr_r  <= `CPSC_TCR2_ADDR;
              spi_wdata_r <= tcr2_byte(1'b0, pts_r, 1'b0, 1'b0);
              ret_r       <= S_CHG_RUN;
              state_r     <= S_XFER;
            end
          end else if (cmd_wr && (sw_wdata[`CPSC_CMD_SEL_RES] || sw_wdata[`CPSC_CMD_DISCHARGE] ||
                                  sw_wdata[`CPSC_CMD_SEL_MAIN])) begin
            if (sw_wdata[`CPSC_CMD_SEL_MAIN] && !sw_wdata[`CPSC_CMD_SEL_RES] &&
                !sw_wdata[`CPSC_CMD_DISCHARGE] && (charged_r || tx_enable_r)) begin
              ev_r[`CPSC_EV_REFUSED] <= 1'b1;
            end else begin
              // break before make: a frame with both cleared first
              want_res_r  <= sw_wdata[`CPSC_CMD_SEL_RES] || sw_wdata[`CPSC_CMD_DISCHARGE];
              dis_op_r    <= sw_wdata[`CPSC_CMD_DISCHARGE];
              res_r       <= 1'b0;
              main_r      <= 1'b0;
              spi_start_r <= 1'b1;
              spi_rd_r    <= `CPSC_FRAME_WRITE;
              spi_addr_r  <= `CPSC_TCR2_ADDR;
              spi_wdata_r <= tcr2_byte(1'b0, pts_r, 1'b0, 1'b0);
              ret_r       <= S_SEL_SET;
              state_r     <= S_XFER;
            end
          end
        end
        S_XFER: begin
          if (spi_done)
            state_r <= ret_r;
        end
        S_CHG_RUN: begin
          run_r       <= 1'b1;
          spi_start_r <= 1'b1;
          spi_rd_r    <= `CPSC_FRAME_WRITE;
          spi_addr_r  <= `CPSC_TCR2_ADDR;
          spi_wdata_r <= tcr2_byte(1'b1, pts_r, 1'b0, 1'b0);
          ret_r       <= S_POLL_WAIT;
          state_r     <= S_XFER;
        end
        S_POLL_WAIT: begin
          if (abort_pend_r) begin
            abort_pend_r <= 1'b0;
            run_r        <= 1'b0;
            ev_r[`CPSC_EV_CHG_ABORT] <= 1'b1;
            spi_start_r  <= 1'b1;
            spi_rd_r     <= `CPSC_FRAME_WRITE;
            spi_addr_r   <= `CPSC_TCR2_ADDR;
            spi_wdata_r  <= tcr2_byte(1'b0, pts_r, 1'b0, 1'b0);
            ret_r        <= S_IDLE;
            state_r      <= S_XFER;
          end else if (ms_tick) begin
            spi_start_r <= 1'b1;
            spi_rd_r    <= `CPSC_FRAME_READ;
            spi_addr_r  <= `CPSC_TCR2_ADDR;
            spi_wdata_r <= `CPSC_BYTE_ZERO;
            ret_r       <= S_POLL_CHK;
            state_r     <= S_XFER;
          end
        end
        S_POLL_CHK: begin
          // device drops pump_run itself on timeout or voltage limit
          run_r <= spi_rdata[`CPSC_TCR2_RUN];
          if (!spi_rdata[`CPSC_TCR2_RUN]) begin
            charged_r    <= !abort_pend_r;
            abort_pend_r <= 1'b0;
            ev_r[`CPSC_EV_CHG_DONE] <= 1'b1;
            state_r      <= S_IDLE;
          end else begin
            state_r <= S_POLL_WAIT;
          end
        end
        S_SEL_SET: begin
          res_r       <= want_res_r;
          main_r      <= !want_res_r;
          spi_start_r <= 1'b1;
          spi_rd_r    <= `CPSC_FRAME_WRITE;
          spi_addr_r  <= `CPSC_TCR2_ADDR;
          spi_wdata_r <= tcr2_byte(1'b0, pts_r, want_res_r, !want_res_r);
          ret_r       <= dis_op_r ? S_DIS_BIT : S_IDLE;
          state_r     <= S_XFER;
        end
        S_DIS_BIT: begin
          dis_r       <= 1'b1;
          dis_cnt_r   <= dis_ms_r;
          spi_start_r <= 1'b1;
          spi_rd_r    <= `CPSC_FRAME_WRITE;
          spi_addr_r  <= `CPSC_TRIM_ADDR;
          spi_wdata_r <= `CPSC_BYTE_ZERO | (8'h01 << `CPSC_TRIM_DIS);
          ret_r       <= S_DIS_WAIT;
          state_r     <= S_XFER;
        end
        S_DIS_WAIT: begin
          if (ms_tick && dis_cnt_r == 8'h00) begin
            xmt_reset_n_r <= 1'b0;
            state_r       <= S_RESET;
          end else if (ms_tick) begin
            dis_cnt_r <= dis_cnt_r - 1'b1;
          end
        end
        S_RESET: begin
          if (ms_tick) begin
            // the transmitter reset clears the device bits; mirror that here
            xmt_reset_n_r <= 1'b1;
            dis_r         <= 1'b0;
            res_r         <= 1'b0;
            main_r        <= 1'b0;
            run_r         <= 1'b0;
            charged_r     <= 1'b0;
            dis_op_r      <= 1'b0;
            ev_r[`CPSC_EV_DIS_DONE] <= 1'b1;
            state_r       <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // transmit duty guard, counted in milliseconds
  always @(posedge clk) begin
    if (!reset_n) begin
      tx_enable_r <= 1'b0;
      tx_len_r    <= 16'h0000;
      hold_r      <= 16'h0000;
      consumed_r  <= 1'b0;
      hold_over_r <= 1'b0;
      tx_cut_r    <= 1'b0;
    end else begin
      consumed_r  <= 1'b0;
      hold_over_r <= 1'b0;
      tx_cut_r    <= 1'b0;
      if (!tx_enable_r) begin
        if (tx_req && tx_ok) begin
          tx_enable_r <= 1'b1;
          tx_len_r    <= 16'h0000;
        end
        if (ms_tick && hold_r != 16'h0000) begin
          hold_r      <= hold_r - 1'b1;
          hold_over_r <= (hold_r == 16'h0001);
        end
      end else if (tx_end || (ms_tick && tx_len_r == `CPSC_TX_MAX_MS - 1'b1)) begin
        // cut short of one second; silence is the longer of the two limits
        tx_enable_r <= 1'b0;
        tx_cut_r    <= !tx_end;
        consumed_r  <= 1'b1;
        hold_r      <= (hold_mul > `CPSC_HOLD_MIN_MS) ? hold_mul : `CPSC_HOLD_MIN_MS;
      end else if (ms_tick) begin
        tx_len_r <= tx_len_r + 1'b1;
      end
    end
  end

  // software registers, status cleared by read, set wins over the clear
  always @(posedge clk) begin
    if (!reset_n) begin
      pts_r      <= `CPSC_CFG_RESET;
      dis_ms_r   <= `CPSC_DIS_MS_RESET;
      mask_r     <= 6'h00;
      status_r   <= 6'h00;
      sw_rdata_r <= 8'h00;
      irq_r      <= 1'b0;
    end else begin
      if (sw_wr && sw_addr == `CPSC_A_CFG)
        pts_r <= sw_wdata[1:0];
      if (sw_wr && sw_addr == `CPSC_A_DIS_MS)
        dis_ms_r <= sw_wdata;
      if (sw_wr && sw_addr == `CPSC_A_MASK)
        mask_r <= sw_wdata[5:0];
      status_r <= (status_r & ~((sw_rd && sw_addr == `CPSC_A_STATUS) ? 6'h3F : 6'h00)) |
                  ev_r | {hold_over_r, tx_cut_r, 4'h0} |
                  {2'b00, (tx_req && !tx_ok), 3'b000};
      irq_r <= |(status_r & mask_r);
      sw_rdata_r <= 8'h00;
      if (sw_rd) begin
        case (sw_addr)
          `CPSC_A_CFG:    sw_rdata_r <= {6'h00, pts_r};
          `CPSC_A_DIS_MS: sw_rdata_r <= dis_ms_r;
          `CPSC_A_STATUS: sw_rdata_r <= {2'b00, status_r};
          `CPSC_A_MASK:   sw_rdata_r <= {2'b00, mask_r};
          `CPSC_A_STATE:  sw_rdata_r <= {dis_r, tx_enable_r, (hold_r != 16'h0000), charged_r,
                                         main_r, res_r, run_r, busy};
          default:        sw_rdata_r <= 8'h00;
        endcase
      end
    end
  end

endmodule // cpsc_supply_ctrl

// ==== logic/cpsc_regs.vh ====
/*
  Constants of the charge pump supply controller: device register map over
  the serial register port, control-register bit layout, software register
  map of the controller, and timing figures.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef CPSC_REGS_VH
`define CPSC_REGS_VH

// device side registers (7-bit register address in the serial frame)
`define CPSC_TRIM_ADDR      7'h08
`define CPSC_TCR2_ADDR      7'h02
`define CPSC_FRAME_READ     1'b1
`define CPSC_FRAME_WRITE    1'b0
`define CPSC_FRAME_BITS     5'h10

// transmitter_control_two bit layout
`define CPSC_TCR2_MAIN      0
`define CPSC_TCR2_RES       1
`define CPSC_TCR2_PTS_LO    2
`define CPSC_TCR2_PTS_HI    3
`define CPSC_TCR2_RUN       4

// rf_trim_control_one bit layout
`define CPSC_TRIM_DIS       5

// controller software registers
`define CPSC_A_CMD          4'h0
`define CPSC_A_CFG          4'h1
`define CPSC_A_DIS_MS       4'h2
`define CPSC_A_STATUS       4'h3
`define CPSC_A_MASK         4'h4
`define CPSC_A_STATE        4'h5

// command bits (write-only pulses)
`define CPSC_CMD_CHARGE     0
`define CPSC_CMD_ABORT      1
`define CPSC_CMD_SEL_RES    2
`define CPSC_CMD_SEL_MAIN   3
`define CPSC_CMD_DISCHARGE  4
`define CPSC_CMD_TX_START   6
`define CPSC_CMD_TX_STOP    7

// status / mask bits
`define CPSC_EV_CHG_DONE    0
`define CPSC_EV_CHG_ABORT   1
`define CPSC_EV_DIS_DONE    2
`define CPSC_EV_REFUSED     3
`define CPSC_EV_TX_CUT      4
`define CPSC_EV_HOLD_OVER   5

// reset values
`define CPSC_CFG_RESET      2'h0
`define CPSC_DIS_MS_RESET   8'h0A
`define CPSC_BYTE_ZERO      8'h00

// timing
`define CPSC_CLK_NS         40
`define CPSC_MS_NS          1000000
`define CPSC_SPI_HALF       4'h2
`define CPSC_TX_MAX_MS      16'h03E8
`define CPSC_HOLD_MIN_MS    16'h2710
`define CPSC_HOLD_MULT      16'h001E

`endif

// ==== logic/cpsc_ms_timer.v ====
/*
  Millisecond tick divider: one-cycle enable pulse every MS_CYCLES clocks.
  Assumes a single free-running clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "cpsc_regs.vh"

module cpsc_ms_timer #(
  parameter MS_CYCLES = `CPSC_MS_NS / `CPSC_CLK_NS,
  parameter CNT_W     = 16
) (
  // clock and reset
  input  wire             clk,
  input  wire             reset_n,
  // tick out
  output reg              tick_r
);

  reg [CNT_W-1:0] cnt_r;

  always @(posedge clk) begin
    if (!reset_n) begin
      cnt_r  <= {CNT_W{1'b0}};
      tick_r <= 1'b0;
    end else if (cnt_r == MS_CYCLES[CNT_W-1:0] - 1'b1) begin
      cnt_r  <= {CNT_W{1'b0}};
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

endmodule // cpsc_ms_timer

// ==== logic/cpsc_spi_master.v ====
/*
  Serial register port master: 16-bit frame, MSB first, clock idle low,
  data changed on the falling edge and sampled on the rising edge.
  Frame: bit 15 read flag, bits 14:8 register address, bits 7:0 data.
  Assumes the device drives its read data during the last 8 bits.
*/
`timescale 1ns/1ps
`include "cpsc_regs.vh"

module cpsc_spi_master #(
  parameter HALF = `CPSC_SPI_HALF
) (
  // clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // request
  input  wire       start,
  input  wire       rd,
  input  wire [6:0] addr,
  input  wire [7:0] wdata,
  output reg        busy_r,
  output reg        done_r,
  output reg  [7:0] rdata_r,
  // pins
  output reg        sck_r,
  output reg        mosi_r,
  output reg        cs_n_r,
  input  wire       miso
);

  reg [15:0] sh_r;
  reg [4:0]  bits_r;
  reg [3:0]  div_r;

  always @(posedge clk) begin
    if (!reset_n) begin
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
      rdata_r <= 8'h00;
      sck_r   <= 1'b0;
      mosi_r  <= 1'b0;
      cs_n_r  <= 1'b1;
      sh_r    <= 16'h0000;
      bits_r  <= 5'h00;
      div_r   <= 4'h0;
    end else begin
      done_r <= 1'b0;
      if (!busy_r) begin
        if (start) begin
          busy_r <= 1'b1;
          cs_n_r <= 1'b0;
          sh_r   <= {rd, addr, wdata};
          mosi_r <= rd;
          bits_r <= 5'h00;
          div_r  <= 4'h0;
        end
      end else if (div_r != HALF - 1'b1) begin
        div_r <= div_r + 1'b1;
      end else begin
        div_r <= 4'h0;
        if (bits_r == `CPSC_FRAME_BITS && !sck_r) begin
          // one half period of deselect hold before release
          busy_r <= 1'b0;
          done_r <= 1'b1;
          cs_n_r <= 1'b1;
          mosi_r <= 1'b0;
          rdata_r <= sh_r[7:0];
        end else if (!sck_r) begin
          sck_r <= 1'b1;
          sh_r  <= {sh_r[14:0], miso};
          bits_r <= bits_r + 1'b1;
        end else begin
          sck_r  <= 1'b0;
          mosi_r <= sh_r[15];
        end
      end
    end
  end

endmodule // cpsc_spi_master

// ==== testbench/cpsc_sc_asserts.sv ====
/*
  Checker for the supply controller ports: serial frame shape, read-data
  window, transmitter reset pulse and transmit length.
  Assumes MS_CYCLES matches the bound instance; one clock domain.
*/
`timescale 1ns/1ps
module cpsc_sc_asserts #(
  parameter MS_CYCLES = 25000
) (
  // clock and reset
  input wire       clk,
  input wire       reset_n,
  // software port
  input wire [3:0] sw_addr,
  input wire [7:0] sw_wdata,
  input wire       sw_wr,
  input wire       sw_rd,
  input wire [7:0] sw_rdata_r,
  input wire       irq_r,
  // device pins
  input wire       spi_sck,
  input wire       spi_mosi,
  input wire       spi_cs_n,
  input wire       spi_miso,
  input wire       xmt_reset_n_r,
  input wire       tx_enable_r
);
  localparam int TX_LIM = 1000 * MS_CYCLES;
  int rst_cnt;
  int tx_cnt;
  // lengths counted in helper logic; repetition would unroll too far
  always @(posedge clk) begin
    if (!reset_n) begin
      rst_cnt <= 0;
      tx_cnt  <= 0;
    end else begin
      rst_cnt <= xmt_reset_n_r ? 0 : rst_cnt + 1;
      tx_cnt  <= tx_enable_r ? tx_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_frame_open;
    $fell(spi_cs_n);
  endsequence
  sequence s_frame_close;
    $rose(spi_cs_n);
  endsequence
  sequence s_sck_pulse;
    ##1 spi_sck ##1 !spi_sck;
  endsequence
  a_rdata_idle: assert property (!$past(sw_rd) |-> sw_rdata_r == 8'h00)
    else $error("read data outside its window");
  a_sck_idle: assert property (spi_cs_n |-> !spi_sck)
    else $error("serial clock active while deselected");
  a_sck_high: assert property ($rose(spi_sck) |-> s_sck_pulse)
    else $error("serial clock high phase not two cycles");
  a_mosi_hold: assert property ($rose(spi_sck) |=> $stable(spi_mosi))
    else $error("serial data moved while clock high");
  a_frame_len: assert property (s_frame_open |-> ##[60:72] s_frame_close)
    else $error("frame length out of range");
  a_frame_gap: assert property (s_frame_close |=> spi_cs_n)
    else $error("frames too close");
  a_rst_pulse: assert property ($rose(xmt_reset_n_r) |-> rst_cnt >= MS_CYCLES - 1 && rst_cnt <= MS_CYCLES + 1)
    else $error("transmitter reset pulse not one millisecond");
  a_tx_max: assert property (tx_cnt <= TX_LIM)
    else $error("transmission longer than one second");
endmodule // cpsc_sc_asserts

bind cpsc_supply_ctrl cpsc_sc_asserts #(.MS_CYCLES(MS_CYCLES)) chk_u (
  .clk(clk), .reset_n(reset_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
  .sw_rdata_r(sw_rdata_r), .irq_r(irq_r), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_cs_n(spi_cs_n),
  .spi_miso(spi_miso), .xmt_reset_n_r(xmt_reset_n_r), .tx_enable_r(tx_enable_r));

// ==== testbench/cpsc_dev_model.sv ====
/*
  Behavioural transmitter device: control and trim registers behind the
  serial port, pump timer, synchronised charge limit, discharge bit.
  Assumes frames as the controller sends them; the pump clock is clk here.
*/
`timescale 1ns/1ps
`include "cpsc_regs.vh"
module cpsc_dev_model #(
  parameter TO_BASE = 60
) (
  // clock and reset
  input  wire clk,
  input  wire reset_n,
  // serial register port
  input  wire spi_sck,
  input  wire spi_mosi,
  input  wire spi_cs_n,
  output reg  spi_miso = 1'b0,
  // device pins
  input  wire xmt_reset_n,
  input  wire limit_in,
  output wire pump_run,
  output wire reservoir_supply_select,
  output wire main_supply_select,
  output wire discharge_on
);
  reg  [7:0]  tcr2_r;
  reg  [7:0]  trim_r;
  reg  [15:0] sh_r;
  reg  [7:0]  dout_r;
  reg  [4:0]  cnt_r;
  reg  [11:0] tmr_r;
  reg  [1:0]  lim_r;
  reg         sck_q;
  reg         rdf_r;
  wire        rise = spi_sck & ~sck_q;
  wire        fall = ~spi_sck & sck_q;
  wire [7:0]  sel  = (sh_r[6:0] == `CPSC_TCR2_ADDR) ? tcr2_r : (sh_r[6:0] == `CPSC_TRIM_ADDR) ? trim_r : 8'h00;
  wire [11:0] lim  = 12'(TO_BASE) << tcr2_r[`CPSC_TCR2_PTS_HI:`CPSC_TCR2_PTS_LO];
  assign pump_run                = tcr2_r[`CPSC_TCR2_RUN];
  assign reservoir_supply_select = tcr2_r[`CPSC_TCR2_RES];
  assign main_supply_select      = tcr2_r[`CPSC_TCR2_MAIN];
  assign discharge_on            = trim_r[`CPSC_TRIM_DIS];
  always @(posedge clk) begin
    sck_q <= spi_sck;
    lim_r <= {lim_r[0], limit_in};
    if (!reset_n || !xmt_reset_n) begin
      tcr2_r <= 8'h00;
      trim_r <= 8'h00;
      tmr_r  <= 12'h000;
    end else if (tcr2_r[`CPSC_TCR2_RUN]) begin
      tmr_r <= tmr_r + 12'h001;
      if (tmr_r == lim - 12'h001 || lim_r[1]) begin
        tcr2_r[`CPSC_TCR2_RUN] <= 1'b0;
        tmr_r <= 12'h000;
      end
    end
    if (!reset_n) begin
      cnt_r <= 5'h00;
      rdf_r <= 1'b0;
    end else if (spi_cs_n) begin
      cnt_r <= 5'h00;
      rdf_r <= 1'b0;
      // a released line must not keep its last level
      spi_miso <= ~spi_miso;
      if (cnt_r == 5'h10 && !sh_r[15] && xmt_reset_n) begin
        if (sh_r[14:8] == `CPSC_TCR2_ADDR) begin
          tcr2_r <= sh_r[7:0];
          tmr_r  <= 12'h000;
        end
        if (sh_r[14:8] == `CPSC_TRIM_ADDR)
          trim_r <= sh_r[7:0];
      end
    end else begin
      if (rise) begin
        sh_r  <= {sh_r[14:0], spi_mosi};
        cnt_r <= cnt_r + 5'h01;
      end
      if (fall && cnt_r == 5'h08 && sh_r[7]) begin
        rdf_r    <= 1'b1;
        spi_miso <= sel[7];
        dout_r   <= {sel[6:0], 1'b0};
      end else if (fall && rdf_r && cnt_r < 5'h10) begin
        spi_miso <= dout_r[7];
        dout_r   <= {dout_r[6:0], 1'b0};
      end else if (!rdf_r) begin
        spi_miso <= ~spi_miso;
      end
    end
  end
endmodule // cpsc_dev_model

// ==== testbench/tb.sv ====
/*
  Self-checking bench for the supply controller against the device model.
  Assumes a 25 MHz clock and a shortened millisecond (MS_CYCLES = 20).
*/
`timescale 1ns/1ps
`include "cpsc_regs.vh"
module tb;
  localparam int MS = 20;
  logic       clk      = 1'b0;
  logic       reset_n  = 1'b0;
  logic [3:0] sw_addr  = 4'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic       sw_wr    = 1'b0;
  logic       sw_rd    = 1'b0;
  logic       limit_in = 1'b0;
  logic       rd_d     = 1'b0;
  logic [7:0] rv;
  logic [7:0] exp_q[$];
  wire  [7:0] sw_rdata_r;
  wire        irq_r, spi_sck, spi_mosi, spi_cs_n, spi_miso, xmt_reset_n_r, tx_enable_r;
  wire        pump_run, res_sel, main_sel, dis_on;
  wire  [5:0] sv = {tx_enable_r, dis_on, main_sel, res_sel, pump_run, irq_r};
  int         err_count = 0;
  int         total_checks = 0;
  int         seed = 31862;
  int         n;
  always #20 clk = ~clk;
  cpsc_supply_ctrl #(.MS_CYCLES(MS)) dut_u (.clk(clk), .reset_n(reset_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata_r(sw_rdata_r), .irq_r(irq_r), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
    .spi_cs_n(spi_cs_n), .spi_miso(spi_miso), .xmt_reset_n_r(xmt_reset_n_r), .tx_enable_r(tx_enable_r));
  cpsc_dev_model dev_u (.clk(clk), .reset_n(reset_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_cs_n(spi_cs_n),
    .spi_miso(spi_miso), .xmt_reset_n(xmt_reset_n_r), .limit_in(limit_in), .pump_run(pump_run),
    .reservoir_supply_select(res_sel), .main_supply_select(main_sel), .discharge_on(dis_on));
  task chk(input string what, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task note(input string s);
    $display("test %s done", s);
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    sw_rd <= 1'b0;
  endtask
  // waits are bounded; n keeps the cycles spent for length checks
  task wait_sig(input int w, input logic v, input int lim);
    n = 0;
    while (sv[w] !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      err_count++;
      $display("[ERR] wait on %0d expected %b seen timeout", w, v);
      test_done;
    end
  endtask
  always @(posedge clk) begin
    rd_d <= sw_rd;
    if (rd_d)
      chk("sw_rdata", exp_q.pop_front(), sw_rdata_r);
    if (reset_n && pump_run && (res_sel || main_sel))
      chk("select during charge", 8'h00, 8'h01);
    if (reset_n && res_sel && main_sel)
      chk("both selects", 8'h00, 8'h01);
  end
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd(`CPSC_A_CFG, 8'h00);
    rd(`CPSC_A_DIS_MS, `CPSC_DIS_MS_RESET);
    rd(`CPSC_A_MASK, 8'h00);
    rd(`CPSC_A_STATUS, 8'h00);
    rd(`CPSC_A_STATE, 8'h00);
    for (int a = 6; a < 16; a++)
      rd(4'(a), 8'h00);
    rv = 8'($random(seed));
    wr(`CPSC_A_DIS_MS, rv);
    rd(`CPSC_A_DIS_MS, rv);
    wr(`CPSC_A_CFG, rv);
    rd(`CPSC_A_CFG, {6'h00, rv[1:0]});
    wr(`CPSC_A_DIS_MS, 8'h03);
    wr(`CPSC_A_MASK, 8'h3F);
    note("registers");
    // four timeouts, then an early stop by the voltage limit
    for (int i = 0; i < 5; i++) begin
      wr(`CPSC_A_CFG, (i == 4) ? 8'h03 : 8'(i));
      wr(`CPSC_A_CMD, 8'h01);
      wait_sig(1, 1'b1, 400);
      if (i == 4)
        limit_in <= 1'b1;
      wait_sig(1, 1'b0, 600);
      limit_in <= 1'b0;
      chk("charge length", 8'h01, {7'h00, (i == 4) ? n <= 4 : n >= (60 << i) - 2});
      wait_sig(0, 1'b1, 200);
      rd(`CPSC_A_STATUS, 8'h01);
      rd(`CPSC_A_STATE, 8'h10);
    end
    repeat (2) @(posedge clk);
    chk("irq cleared", 8'h00, {7'h00, irq_r});
    note("charge");
    wr(`CPSC_A_CMD, 8'h01);
    wait_sig(1, 1'b1, 400);
    wr(`CPSC_A_CMD, 8'h02);
    wait_sig(1, 1'b0, 150);
    wait_sig(0, 1'b1, 200);
    rd(`CPSC_A_STATUS, 8'h02);
    note("abort");
    wr(`CPSC_A_CFG, 8'h00);
    wr(`CPSC_A_CMD, 8'h01);
    wait_sig(0, 1'b1, 800);
    rd(`CPSC_A_STATUS, 8'h01);
    wr(`CPSC_A_CMD, 8'h04);
    wait_sig(2, 1'b1, 300);
    chk("main select", 8'h00, {7'h00, main_sel});
    wr(`CPSC_A_CMD, 8'h08);
    wait_sig(0, 1'b1, 50);
    rd(`CPSC_A_STATUS, 8'h08);
    wr(`CPSC_A_CMD, 8'h40);
    wait_sig(5, 1'b1, 50);
    wr(`CPSC_A_CMD, 8'h01);
    wait_sig(5, 1'b0, 21000);
    chk("tx length", 8'h01, {7'h00, n >= 998 * MS});
    repeat (2) @(posedge clk);
    rd(`CPSC_A_STATUS, 8'h18);
    wr(`CPSC_A_CMD, 8'h40);
    wait_sig(0, 1'b1, 50);
    rd(`CPSC_A_STATUS, 8'h08);
    rd(`CPSC_A_STATE, 8'h24);
    wr(`CPSC_A_CMD, 8'h08);
    wait_sig(3, 1'b1, 300);
    chk("reservoir select", 8'h00, {7'h00, res_sel});
    note("transmit");
    wr(`CPSC_A_CMD, 8'h10);
    wait_sig(4, 1'b1, 400);
    chk("reservoir select", 8'h01, {7'h00, res_sel});
    wait_sig(4, 1'b0, 400);
    chk("discharge length", 8'h01, {7'h00, n >= 3 * MS});
    chk("main select", 8'h00, {7'h00, main_sel});
    wait_sig(0, 1'b1, 200);
    rd(`CPSC_A_STATUS, 8'h04);
    rd(`CPSC_A_STATE, 8'h20);
    wr(`CPSC_A_MASK, 8'h00);
    wr(`CPSC_A_CMD, 8'h40);
    repeat (4) @(posedge clk);
    chk("irq masked", 8'h00, {7'h00, irq_r});
    rd(`CPSC_A_STATUS, 8'h08);
    note("discharge");
    test_done;
  end
endmodule // tb
